// >>> logic/ssp_cfg.svh
// register map, field positions, reset values and divider counts of the serial port
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_OFS_MODE 5'h00
`define SSP_OFS_CTRL0 5'h04
`define SSP_OFS_CTRL1 5'h08
`define SSP_OFS_TXBUF 5'h0c
`define SSP_OFS_RXBUF 5'h10
`define SSP_OFS_BRG 5'h14
`define SSP_M_EXT 3
`define SSP_M_STOP 4
`define SSP_M_ODD 5
`define SSP_M_PAR 6
`define SSP_C0_TXEPT 3
`define SSP_C0_RXIM 5
`define SSP_C0_CPL 6
`define SSP_C0_FMT 7
`define SSP_C1_TE 0
`define SSP_C1_TI 1
`define SSP_C1_RE 2
`define SSP_MODE_RST 8'h00
`define SSP_CTRL0_RST 8'h00
`define SSP_BRG_RST 8'h00
`define SSP_PRE_F1 6'h00
`define SSP_PRE_F8 6'h07
`define SSP_PRE_F32 6'h1f
`define SSP_PRE_F64 6'h3f
`define SSP_ASYNC_LAST 4'hf
`define SSP_FRAME_BITS 4'h8
`endif

// >>> logic/ssp_pkg.sv
// types shared by the serial port
`default_nettype none
package ssp_pkg;
  typedef enum logic [2:0] {
    SSP_MODE_OFF = 3'h0,
    SSP_MODE_SYNC = 3'h1,
    SSP_MODE_UART7 = 3'h4,
    SSP_MODE_UART8 = 3'h5,
    SSP_MODE_UART9 = 3'h6
  } ssp_mode_t;
  typedef enum logic [1:0] {
    SSP_TX_IDLE = 2'b00,
    SSP_TX_SHIFT = 2'b01
  } ssp_tx_st_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } ssp_avs_req_t;
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } ssp_avs_rsp_t;
  typedef struct packed {
    logic rxd;
    logic cts_n;
    logic transfer_clock_in;
    logic external_bit_clock;
  } ssp_pin_in_t;
  typedef struct packed {
    logic txd;
    logic rts_n;
    logic transfer_clock_out;
    logic transfer_clock_oe;
    logic async_bit_tick;
  } ssp_pin_out_t;
  typedef struct packed {
    logic tx_irq_req;
    logic rx_irq_req;
    logic rx_dma_req;
  } ssp_evt_t;
endpackage : ssp_pkg
`default_nettype wire

// >>> logic/ssp_top.sv
// serial port: clock-synchronous transfer, bit rate divider and avalon register slave
// Overview of operation
// - start sending only with transmit enabled, buffer full and cts low
// - buffer empty flag clears on buffer write, sets when moved to shifter
// - transmit data leaves lsb first, one bit per transfer clock period
// - a started frame ignores enable, buffer flag and cts until it ends
// - start is checked at frame end too, so frames follow without gap
// - register empty flag sets a cycle after frame end, clears on start
// - buffer empty flag rising raises the transmit interrupt request
// - receive enable arms reception, which starts with the first rising transfer clock edge, own or incoming
// - rts high while receive disabled, low when enabled, high at receive start
// - each rising transfer clock edge samples rxd into the receive shifter
// - after eight bits the shifter moves to receive buffer, complete flag sets
// - reading the receive buffer low byte drives rts low again
// - overrun sets on copy with complete flag still set; clears with receive disable
// - complete flag clears on receive buffer read or receive disable
// - framing, parity and error sum flags are inert in synchronous mode
// - receive interrupt on every frame, or only on overrun when selected
// - dma request on every frame, or only error-free frames when selected
// - polarity picks transmit edge and idle level; receive always samples rising
// - bit order flips on buffer access, the shifter never changes
// - asynchronous mode codes select seven, eight or nine data bits; here all three only enable the async bit clock
// - async bit clock is source divided by rate value plus one, then sixteen
// - mode bits hold stop count, parity sense and parity enable
// - mode code one selects synchronous mode with fixed eight bit frames
// - clock sender divides source by rate value plus one, then two
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`include "ssp_cfg.svh"
`default_nettype none
module ssp_top import ssp_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register bus
  input wire ssp_avs_req_t avs_req,
  output var ssp_avs_rsp_t avs_rsp,
  // serial pins
  input wire ssp_pin_in_t pin_in,
  output var ssp_pin_out_t pin_out,
  // requests to interrupt and dma controllers
  output var ssp_evt_t evt
);

  function automatic logic [7:0] ssp_rev8(input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7 - i];
    end
    return r;
  endfunction : ssp_rev8

  function automatic logic [5:0] ssp_pre_last(input logic [1:0] cs);
    logic [5:0] r;
    r = `SSP_PRE_F1;
    unique case (cs)
      2'b00: r = `SSP_PRE_F1;
      2'b01: r = `SSP_PRE_F8;
      2'b10: r = `SSP_PRE_F32;
      2'b11: r = `SSP_PRE_F64;
    endcase
    return r;
  endfunction : ssp_pre_last

  // pin synchronisers; the third stage only feeds edge detection
  ssp_pin_in_t pin_s1;
  ssp_pin_in_t pin_s2;
  logic clk_s3;
  logic ext_s3;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= '1;
      pin_s2 <= '1;
      clk_s3 <= 1'b1;
      ext_s3 <= 1'b1;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      clk_s3 <= pin_s2.transfer_clock_in;
      ext_s3 <= pin_s2.external_bit_clock;
    end
  end

  // software state
  logic [7:0] mode_reg;
  logic [7:0] ctrl0;
  logic [7:0] brg;
  logic [7:0] tx_buf;
  logic [7:0] rx_buf;
  logic tx_enable_flag;
  logic tx_buffer_empty_flag;
  logic rx_enable_flag;
  logic rx_complete_flag;
  logic overrun_error_flag;
  logic tx_register_empty_flag;

  // mode decode
  wire sync_mode = mode_reg[2:0] == SSP_MODE_SYNC;
  wire async_mode = mode_reg[2:0] == SSP_MODE_UART7 || mode_reg[2:0] == SSP_MODE_UART8
    || mode_reg[2:0] == SSP_MODE_UART9;
  wire ext_sel = mode_reg[`SSP_M_EXT];
  wire master = sync_mode && !ext_sel;
  wire clock_polarity_select = ctrl0[`SSP_C0_CPL];
  wire msb_first = ctrl0[`SSP_C0_FMT];
  wire rx_int_mode = ctrl0[`SSP_C0_RXIM];

  // bus decode
  // a request counts once: waitrequest is low in its answer cycle
  wire acc = (avs_req.read || avs_req.write) && avs_rsp.waitrequest;
  wire wr_go = acc && avs_req.write && avs_req.byteenable[0];
  wire rd_go = acc && avs_req.read;
  wire hit_mode = avs_req.address == `SSP_OFS_MODE;
  wire hit_ctrl0 = avs_req.address == `SSP_OFS_CTRL0;
  wire hit_ctrl1 = avs_req.address == `SSP_OFS_CTRL1;
  wire hit_txbuf = avs_req.address == `SSP_OFS_TXBUF;
  wire hit_rxbuf = avs_req.address == `SSP_OFS_RXBUF;
  wire hit_brg = avs_req.address == `SSP_OFS_BRG;
  wire [7:0] wd = avs_req.writedata[7:0];
  wire txbuf_wr = wr_go && hit_txbuf;
  wire ctrl1_wr = wr_go && hit_ctrl1;
  wire rxbuf_rd = rd_go && hit_rxbuf && avs_req.byteenable[0];
  wire re_set = ctrl1_wr && wd[`SSP_C1_RE] && !rx_enable_flag;
  // error flags of the async receiver read as zero here
  wire [7:0] ctrl1_rd = {3'h0, overrun_error_flag, rx_complete_flag, rx_enable_flag,
    tx_buffer_empty_flag, tx_enable_flag};
  wire [7:0] ctrl0_rd = {ctrl0[7:4], tx_register_empty_flag, ctrl0[2:0]};
  wire [7:0] rxbuf_rd_val = msb_first ? ssp_rev8(rx_buf) : rx_buf;
  // unmapped offsets read zero and still get a normal answer
  wire [7:0] rd_mux = hit_mode ? mode_reg :
    hit_ctrl0 ? ctrl0_rd :
    hit_ctrl1 ? ctrl1_rd :
    hit_rxbuf ? rxbuf_rd_val :
    hit_brg ? brg : 8'h00;

  // bus answer: waitrequest drops for exactly one cycle per access
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_rsp.waitrequest <= 1'b1;
      avs_rsp.readdata <= 32'h0;
    end else begin
      avs_rsp.waitrequest <= !acc;
      avs_rsp.readdata <= rd_go ? {24'h0, rd_mux} : 32'h0;
    end
  end

  // configuration registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= `SSP_MODE_RST;
      ctrl0 <= `SSP_CTRL0_RST;
      brg <= `SSP_BRG_RST;
      tx_enable_flag <= 1'b0;
      rx_enable_flag <= 1'b0;
    end else if (wr_go) begin
      if (hit_mode) mode_reg <= wd;
      if (hit_ctrl0) ctrl0 <= wd;
      if (hit_brg) brg <= wd;
      if (hit_ctrl1) begin
        tx_enable_flag <= wd[`SSP_C1_TE];
        rx_enable_flag <= wd[`SSP_C1_RE];
      end
    end
  end

  // bit rate generator: prescaler or external clock, then divide by rate value plus one
  // one divider serves both modes, so only one rate exists at a time
  logic [5:0] pre_cnt;
  logic [7:0] brg_cnt;
  logic [3:0] os_cnt;
  logic async_tick;
  wire pre_tick = pre_cnt == ssp_pre_last(ctrl0[1:0]);
  wire ext_rise = pin_s2.external_bit_clock && !ext_s3;
  wire src_tick = ext_sel ? ext_rise : pre_tick;
  wire brg_tick = src_tick && brg_cnt == brg;

  // the prescaler free-runs; a rate value lowered below the running count takes effect only after the counter wraps
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pre_cnt <= 6'h00;
      brg_cnt <= 8'h00;
      os_cnt <= 4'h0;
      async_tick <= 1'b0;
    end else begin
      pre_cnt <= pre_tick ? 6'h00 : pre_cnt + 6'h01;
      if (src_tick) brg_cnt <= brg_tick ? 8'h00 : brg_cnt + 8'h01;
      if (brg_tick && async_mode) os_cnt <= os_cnt + 4'h1;
      async_tick <= brg_tick && async_mode && os_cnt == `SSP_ASYNC_LAST;
    end
  end

  // transfer clock events, from own generator or from the peer
  ssp_tx_st_t tx_st;
  ssp_tx_st_t next_tx_st;
  logic xclk;
  logic xclk_oe;
  // the clock only runs while this end transmits
  wire half_tick = brg_tick && master && tx_st == SSP_TX_SHIFT;
  wire m_rise = half_tick && !xclk;
  wire m_fall = half_tick && xclk;
  wire s_rise = sync_mode && ext_sel && pin_s2.transfer_clock_in && !clk_s3;
  wire s_fall = sync_mode && ext_sel && !pin_s2.transfer_clock_in && clk_s3;
  wire rise_ev = m_rise || s_rise;
  wire fall_ev = m_fall || s_fall;
  wire chg_ev = clock_polarity_select ? rise_ev : fall_ev;

  // idle level follows the polarity one cycle after it changes while no frame runs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xclk <= 1'b1;
      xclk_oe <= 1'b0;
    end else begin
      xclk_oe <= master;
      if (tx_st != SSP_TX_SHIFT) xclk <= !clock_polarity_select;
      else if (half_tick) xclk <= !xclk;
    end
  end

  // transmitter
  logic [7:0] tx_sh;
  logic [3:0] tx_cnt;
  logic txd;
  logic tend_q;
  logic ti_q;
  wire tend = tx_st == SSP_TX_IDLE;
  wire cts_low = !pin_s2.cts_n;
  // the last bit stays half a period before the frame is closed, a full period with external clock and polarity set
  wire last_ev = (master && clock_polarity_select) ? fall_ev : rise_ev;
  wire tx_done = tx_st == SSP_TX_SHIFT && tx_cnt == `SSP_FRAME_BITS && last_ev;
  wire start_ok = sync_mode && tx_enable_flag && !tx_buffer_empty_flag && cts_low;
  wire tx_load = start_ok && (tend || tx_done);
  wire tx_shift = tx_st == SSP_TX_SHIFT && chg_ev && tx_cnt != `SSP_FRAME_BITS;

  always_comb begin
    next_tx_st = tx_st;
    unique case (tx_st)
      SSP_TX_IDLE: if (tx_load) next_tx_st = SSP_TX_SHIFT;
      SSP_TX_SHIFT: if (tx_done && !tx_load) next_tx_st = SSP_TX_IDLE;
      default: next_tx_st = SSP_TX_IDLE;
    endcase
  end

  // txd keeps its last bit between frames; the peer samples only on clock edges
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_st <= SSP_TX_IDLE;
      tx_sh <= 8'h00;
      tx_cnt <= 4'h0;
      txd <= 1'b1;
    end else begin
      tx_st <= next_tx_st;
      if (tx_load) begin
        tx_sh <= tx_buf;
        tx_cnt <= 4'h0;
      end else if (tx_shift) begin
        txd <= tx_sh[0];
        tx_sh <= {1'b0, tx_sh[7:1]};
        tx_cnt <= tx_cnt + 4'h1;
      end
    end
  end

  // transmit buffer and its flags
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_buf <= 8'h00;
      tx_buffer_empty_flag <= 1'b1;
      tx_register_empty_flag <= 1'b1;
      tend_q <= 1'b1;
      ti_q <= 1'b1;
    end else begin
      if (txbuf_wr) tx_buf <= msb_first ? ssp_rev8(wd) : wd;
      // new data written in the load cycle must not be marked empty
      if (txbuf_wr) tx_buffer_empty_flag <= 1'b0;
      else if (tx_load) tx_buffer_empty_flag <= 1'b1;
      tend_q <= tend;
      if (tx_load) tx_register_empty_flag <= 1'b0;
      else if (tend && !tend_q) tx_register_empty_flag <= 1'b1;
      ti_q <= tx_buffer_empty_flag;
    end
  end

  // receiver
  logic [7:0] rx_sh;
  logic [2:0] rx_cnt;
  logic rts_n;
  logic rx_irq;
  logic rx_dma;
  logic tx_irq;
  // reception ignores rts: a peer that ignores it is still sampled
  wire rx_take = rise_ev && rx_enable_flag;
  wire rx_last = rx_take && rx_cnt == 3'h7;
  wire [7:0] rx_word = {pin_s2.rxd, rx_sh[7:1]};
  // a read in the same cycle empties the buffer first, so no overrun
  wire overrun = rx_last && rx_complete_flag && !rxbuf_rd;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_sh <= 8'h00;
      rx_cnt <= 3'h0;
      rx_buf <= 8'h00;
    end else if (!rx_enable_flag) begin
      rx_cnt <= 3'h0;
    end else if (rx_take) begin
      rx_sh <= rx_word;
      rx_cnt <= rx_cnt + 3'h1;
      if (rx_last) rx_buf <= rx_word;
    end
  end

  // a new frame always replaces the buffer; overrun only records the loss
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_complete_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
    end else if (!rx_enable_flag) begin
      rx_complete_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
    end else begin
      if (rx_last) rx_complete_flag <= 1'b1;
      else if (rxbuf_rd) rx_complete_flag <= 1'b0;
      if (overrun) overrun_error_flag <= 1'b1;
    end
  end

  // request to send
  // disabling receive wins over every other rts cause
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rts_n <= 1'b1;
    end else if (!rx_enable_flag) begin
      rts_n <= !re_set;
    end else if (rx_take && rx_cnt == 3'h0) begin
      rts_n <= 1'b1;
    end else if (rxbuf_rd) begin
      rts_n <= 1'b0;
    end
  end

  // interrupt and dma requests, one-cycle pulses
  // pulses rather than levels: the request bits live in the interrupt controller
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
      rx_dma <= 1'b0;
    end else begin
      tx_irq <= tx_buffer_empty_flag && !ti_q;
      rx_irq <= rx_last && (!rx_int_mode || overrun);
      rx_dma <= rx_last && (!rx_int_mode || !overrun);
    end
  end

  assign pin_out = '{
    txd: txd,
    rts_n: rts_n,
    transfer_clock_out: xclk,
    transfer_clock_oe: xclk_oe,
    async_bit_tick: async_tick
  };

  assign evt = '{
    tx_irq_req: tx_irq,
    rx_irq_req: rx_irq,
    rx_dma_req: rx_dma
  };

endmodule : ssp_top
`default_nettype wire

// >>> verif/ssp_top_sva.sv
// assertions on the serial port top-level ports
`include "ssp_cfg.svh"
`default_nettype none
module ssp_top_sva import ssp_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // watched ports
  input wire ssp_avs_req_t avs_req,
  input wire ssp_avs_rsp_t avs_rsp,
  input wire ssp_pin_in_t pin_in,
  input wire ssp_pin_out_t pin_out,
  input wire ssp_evt_t evt
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence taken_s;
    (avs_req.read || avs_req.write) && avs_rsp.waitrequest;
  endsequence
  // rts only drops while an enable write or a buffer read is being answered
  sequence rts_cause_s;
    avs_req.write && avs_req.address == `SSP_OFS_CTRL1 || avs_req.read && avs_req.address == `SSP_OFS_RXBUF;
  endsequence
  bus_answer_a: assert property (taken_s |=> !avs_rsp.waitrequest)
    else $error("bus answer late");
  bus_stand_a: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
    else $error("bus answer held too long");
  idle_data_a: assert property (avs_rsp.waitrequest |-> avs_rsp.readdata == 32'h0)
    else $error("read data outside answer");
  tx_edge_a: assert property ($changed(pin_out.txd) |-> $changed(pin_out.transfer_clock_out))
    else $error("txd moved off a clock edge");
  rts_low_a: assert property ($fell(pin_out.rts_n) |-> rts_cause_s)
    else $error("rts dropped without cause");
  tx_irq_a: assert property (evt.tx_irq_req |=> !evt.tx_irq_req)
    else $error("tx request not a pulse");
  rx_irq_a: assert property (evt.rx_irq_req |=> !evt.rx_irq_req)
    else $error("rx request not a pulse");
  rx_dma_a: assert property (evt.rx_dma_req |=> !evt.rx_dma_req)
    else $error("dma request not a pulse");
  tick_gap_a: assert property (pin_out.async_bit_tick |=> !pin_out.async_bit_tick [*8])
    else $error("bit ticks too close");
endmodule : ssp_top_sva
bind ssp_top ssp_top_sva ssp_top_sva_inst (.core_clk(core_clk), .rst(rst), .avs_req(avs_req),
  .avs_rsp(avs_rsp), .pin_in(pin_in), .pin_out(pin_out), .evt(evt));
`default_nettype wire

// >>> verif/ssp_peer.sv
// behavioural peer port: clock receiver returning a byte each frame
`default_nettype none
module ssp_peer (
  // reset
  input wire logic rst,
  // link
  input wire logic transfer_clock,
  input wire logic txd,
  output var logic rxd,
  // bench side
  input wire logic [7:0] peer_tx,
  output var logic [7:0] peer_got,
  output var int frames
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] nf = 3'h0;
  logic [2:0] nr = 3'h0;
  logic [7:0] sh = 8'h00;
  initial begin
    rxd = 1'b1;
    peer_got = 8'h00;
    frames = 0;
  end
  // edges during reset are power-up noise, not link traffic
  always @(negedge transfer_clock) begin
    if (!rst) begin
      rxd <= peer_tx[nf];
      nf <= nf + 3'h1;
    end
  end
  always @(posedge transfer_clock) begin
    if (!rst) begin
      sh <= {txd, sh[7:1]};
      nr <= nr + 3'h1;
      if (nr == 3'h7) begin
        peer_got <= {txd, sh[7:1]};
        frames <= frames + 1;
      end
    end
  end
endmodule : ssp_peer
`default_nettype wire

// >>> verif/ssp_top_tb.sv
// self-checking bench for the serial port top
`include "ssp_cfg.svh"
`default_nettype none
module ssp_top_tb import ssp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cts_n = 1'b0;
  // free-running external rate source, one rise every two core cycles
  logic ext_clk = 1'b0;
  logic [7:0] peer_tx = 8'h3c;
  logic [7:0] rdv;
  ssp_avs_req_t req = '{1'b0, 1'b0, 5'h00, 32'h0, 4'h1};
  ssp_avs_rsp_t rsp;
  ssp_pin_in_t pin_in;
  ssp_pin_out_t pin_out;
  ssp_evt_t evt;
  wire logic rxd;
  wire logic clk_line;
  wire logic [7:0] peer_got;
  int frames;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_txi = 0;
  int n_rxi = 0;
  int n_dma = 0;
  int n_tick = 0;
  int t0;
  // shared clock line has a pull-up, idle high while nobody drives
  assign clk_line = pin_out.transfer_clock_oe ? pin_out.transfer_clock_out : 1'b1;
  assign pin_in = '{rxd, cts_n, clk_line, ext_clk};
  ssp_top ssp_top_inst (.core_clk(core_clk), .rst(rst), .avs_req(req), .avs_rsp(rsp), .pin_in(pin_in),
    .pin_out(pin_out), .evt(evt));
  ssp_peer ssp_peer_inst (.rst(rst), .transfer_clock(clk_line), .txd(pin_out.txd), .rxd(rxd),
    .peer_tx(peer_tx), .peer_got(peer_got), .frames(frames));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    ext_clk <= ~ext_clk;
    n_txi <= n_txi + int'(evt.tx_irq_req === 1'b1);
    n_rxi <= n_rxi + int'(evt.rx_irq_req === 1'b1);
    n_dma <= n_dma + int'(evt.rx_dma_req === 1'b1);
    n_tick <= n_tick + int'(pin_out.async_bit_tick === 1'b1);
    if (cycles == 5000) begin
      fail_count++;
      $display("MISMATCH %0t timeout", $time);
      end_sim;
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task access(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req.read <= !wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= {24'h0, d};
    do @(posedge core_clk); while (rsp.waitrequest !== 1'b0);
    rdv = rsp.readdata[7:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : access
  task rc(input logic [4:0] a, input logic [7:0] exp);
    access(1'b0, a, 8'h00);
    chk(rdv, exp);
  endtask : rc
  task wait_bit(input int b);
    rdv = 8'h00;
    while (rdv[b] !== 1'b1) access(1'b0, `SSP_OFS_CTRL1, 8'h00);
  endtask : wait_bit
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rc(`SSP_OFS_MODE, 8'h00);
    rc(`SSP_OFS_CTRL0, 8'h08);
    rc(`SSP_OFS_CTRL1, 8'h02);
    rc(5'h1c, 8'h00);
    access(1'b1, `SSP_OFS_BRG, 8'h03);
    access(1'b1, `SSP_OFS_MODE, 8'h01);
    cts_n <= 1'b1;
    access(1'b1, `SSP_OFS_CTRL1, 8'h05);
    chk({7'h0, pin_out.rts_n}, 8'h00);
    access(1'b1, `SSP_OFS_TXBUF, 8'ha5);
    rc(`SSP_OFS_CTRL0, 8'h08);
    rc(`SSP_OFS_CTRL1, 8'h05);
    cts_n <= 1'b0;
    wait_bit(`SSP_C1_TI);
    access(1'b1, `SSP_OFS_TXBUF, 8'h5a);
    wait_bit(`SSP_C1_TI);
    cts_n <= 1'b1;
    chk(peer_got, 8'ha5);
    while (frames < 2) @(posedge core_clk);
    chk(peer_got, 8'h5a);
    wait_bit(4);
    rc(`SSP_OFS_CTRL1, 8'h1f);
    rc(`SSP_OFS_CTRL0, 8'h08);
    chk({7'h0, pin_out.rts_n}, 8'h01);
    rc(`SSP_OFS_RXBUF, 8'h3c);
    chk({7'h0, pin_out.rts_n}, 8'h00);
    rc(`SSP_OFS_CTRL1, 8'h17);
    chk(8'(n_txi), 8'h02);
    chk(8'(n_rxi), 8'h02);
    chk(8'(n_dma), 8'h02);
    access(1'b1, `SSP_OFS_CTRL1, 8'h01);
    rc(`SSP_OFS_CTRL1, 8'h03);
    chk({7'h0, pin_out.rts_n}, 8'h01);
    access(1'b1, `SSP_OFS_CTRL0, 8'ha0);
    peer_tx <= 8'h12;
    cts_n <= 1'b0;
    access(1'b1, `SSP_OFS_CTRL1, 8'h05);
    access(1'b1, `SSP_OFS_TXBUF, 8'h01);
    while (frames < 3) @(posedge core_clk);
    chk(peer_got, 8'h80);
    wait_bit(3);
    rc(`SSP_OFS_RXBUF, 8'h48);
    chk(8'(n_rxi), 8'h02);
    chk(8'(n_dma), 8'h03);
    access(1'b1, `SSP_OFS_MODE, 8'h75);
    rc(`SSP_OFS_MODE, 8'h75);
    chk({7'h0, pin_out.transfer_clock_oe}, 8'h00);
    t0 = n_tick;
    repeat (192) @(posedge core_clk);
    chk(8'(n_tick - t0), 8'h03);
    access(1'b1, `SSP_OFS_MODE, 8'h7d);
    repeat (128) @(posedge core_clk);
    t0 = n_tick;
    repeat (256) @(posedge core_clk);
    chk(8'(n_tick - t0), 8'h02);
    access(1'b1, `SSP_OFS_MODE, 8'h01);
    access(1'b1, `SSP_OFS_CTRL0, 8'h40);
    // the idle level follows the polarity one edge after the register changes
    @(posedge core_clk);
    chk({7'h0, pin_out.transfer_clock_out}, 8'h00);
    chk({7'h0, pin_out.transfer_clock_oe}, 8'h01);
    end_sim;
  end
endmodule : ssp_top_tb
`default_nettype wire
